// file: hw/pwmg_top.sv
// waveform generator with axi4-lite register slave
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
module pwmg_top (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        trig_in,
    input  wire logic        debug_halt,
    output logic             pwm_out,
    output logic             irq,
    output logic             dma_req
);
    // axi write/read channel state
    logic              aw_have_r, aw_have_nxt;
    logic              w_have_r, w_have_nxt;
    logic [4:0]        aw_addr_r, aw_addr_nxt;
    logic [31:0]       w_data_r, w_data_nxt;
    logic [3:0]        w_strb_r, w_strb_nxt;
    logic              bvalid_r, bvalid_nxt;
    logic [1:0]        bresp_r, bresp_nxt;
    logic              rvalid_r, rvalid_nxt;
    logic [1:0]        rresp_r, rresp_nxt;
    logic [31:0]       rdata_r, rdata_nxt;
    logic              awready_r, wready_r, arready_r;
    logic              awready_nxt, wready_nxt, arready_nxt;
    // software registers
    pwmg_pkg::pwmg_cfg_t cfg_r, cfg_nxt;
    logic              free_r, free_nxt;
    logic [7:0]        burst_repeat_count_r, burst_repeat_count_nxt;
    logic [31:0]       period_length_r, period_length_nxt;
    logic [31:0]       first_phase_length_r, first_phase_length_nxt;
    logic [1:0]        ist_r, ist_nxt;
    logic [1:0]        imsk_r, imsk_nxt;
    // generator state
    pwmg_pkg::pwmg_state_t st_r, st_nxt;
    logic [31:0]       cnt_r, cnt_nxt;
    logic [31:0]       sh_per_r, sh_per_nxt;
    logic [31:0]       sh_ph1_r, sh_ph1_nxt;
    logic [7:0]        left_r, left_nxt;
    logic              out_r, out_nxt;
    logic              trig_d_r;
    logic              edge_seen_r, edge_seen_nxt;
    logic              irq_r, irq_nxt;
    logic              dma_r, dma_nxt;

    logic              do_write;
    logic              start_pulse;
    logic              edge_now;
    logic              halted;
    logic              period_end;
    logic              gen_event;
    logic              done_event;

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        for (int i = 0; i < 4; i++)
            r[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        return r;
    endfunction

    function automatic logic addr_ok(input logic [4:0] a);
        return a[1:0] == 2'h0; // every word slot of the 5-bit space is mapped
    endfunction

    assign do_write    = aw_have_r && w_have_r && !bvalid_r;
    assign start_pulse = do_write && aw_addr_r == pwmg_pkg::ADDR_RUN && w_strb_r[0] && w_data_r[0];
    assign halted      = debug_halt && !free_r;
    assign edge_now    = (cfg_r.trigger_edge_select == pwmg_pkg::TRIG_RISE && trig_in && !trig_d_r)
                      || (cfg_r.trigger_edge_select == pwmg_pkg::TRIG_FALL && !trig_in && trig_d_r);
    assign period_end  = st_r == pwmg_pkg::ST_RUN && !halted && cnt_r == sh_per_r;
    assign done_event  = period_end && cfg_r.mode == pwmg_pkg::MODE_ONE && left_r == 8'h00;
    assign gen_event   = done_event || (period_end && cfg_r.mode == pwmg_pkg::MODE_CONT);

    always_comb
    begin
        aw_have_nxt = aw_have_r;
        w_have_nxt  = w_have_r;
        aw_addr_nxt = aw_addr_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rresp_nxt   = rresp_r;
        rdata_nxt   = rdata_r;
        cfg_nxt     = cfg_r;
        free_nxt    = free_r;
        burst_repeat_count_nxt = burst_repeat_count_r;
        period_length_nxt      = period_length_r;
        first_phase_length_nxt = first_phase_length_r;
        imsk_nxt    = imsk_r;
        ist_nxt     = ist_r;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (do_write)
        begin
            aw_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = addr_ok(aw_addr_r) ? pwmg_pkg::RESP_OKAY : pwmg_pkg::RESP_SLVERR;
            unique case (aw_addr_r)
                pwmg_pkg::ADDR_CTRL: if (w_strb_r[0]) free_nxt = w_data_r[0];
                pwmg_pkg::ADDR_CFG:  if (w_strb_r[0]) cfg_nxt = w_data_r[6:0] & pwmg_pkg::CFG_WMASK;
                pwmg_pkg::ADDR_REPEAT: if (w_strb_r[0]) burst_repeat_count_nxt = w_data_r[7:0];
                pwmg_pkg::ADDR_PER:  period_length_nxt = wmerge(period_length_r, w_data_r, w_strb_r);
                pwmg_pkg::ADDR_PH1:  first_phase_length_nxt = wmerge(first_phase_length_r, w_data_r, w_strb_r);
                pwmg_pkg::ADDR_IMSK: if (w_strb_r[0]) imsk_nxt = w_data_r[1:0];
                pwmg_pkg::ADDR_IST:  if (w_strb_r[0]) ist_nxt = ist_r & ~w_data_r[1:0];
                default: ;
            endcase
        end
        // set wins over clear
        ist_nxt[0] = ist_nxt[0] || done_event;
        ist_nxt[1] = ist_nxt[1] || (gen_event && !done_event);
        if (bvalid_r && s_axi_bready)
            bvalid_nxt = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = addr_ok(s_axi_araddr) ? pwmg_pkg::RESP_OKAY : pwmg_pkg::RESP_SLVERR;
            rdata_nxt  = '0;
            unique case (s_axi_araddr)
                pwmg_pkg::ADDR_CTRL: rdata_nxt[0] = free_r;
                pwmg_pkg::ADDR_CFG:
                begin
                    rdata_nxt[6:0] = cfg_r;
                    rdata_nxt[pwmg_pkg::LEVEL_BIT] = out_r;
                    rdata_nxt[pwmg_pkg::RUN_BIT]   = st_r != pwmg_pkg::ST_IDLE;
                end
                pwmg_pkg::ADDR_REPEAT: rdata_nxt[7:0] = burst_repeat_count_r;
                pwmg_pkg::ADDR_PER:  rdata_nxt = period_length_r;
                pwmg_pkg::ADDR_PH1:  rdata_nxt = first_phase_length_r;
                pwmg_pkg::ADDR_IST:  rdata_nxt[1:0] = ist_r;
                pwmg_pkg::ADDR_IMSK: rdata_nxt[1:0] = imsk_r;
                default: ;
            endcase
        end
        else if (rvalid_r && s_axi_rready)
            rvalid_nxt = 1'b0;
        // readies registered so every bus output leaves a flip-flop
        awready_nxt = !aw_have_nxt && !bvalid_nxt;
        wready_nxt  = !w_have_nxt && !bvalid_nxt;
        arready_nxt = !rvalid_nxt;
    end

    always_comb
    begin
        st_nxt        = st_r;
        cnt_nxt       = cnt_r;
        sh_per_nxt    = sh_per_r;
        sh_ph1_nxt    = sh_ph1_r;
        left_nxt      = left_r;
        out_nxt       = out_r;
        edge_seen_nxt = edge_seen_r || (st_r == pwmg_pkg::ST_ARMED && edge_now);
        irq_nxt       = |(ist_nxt & imsk_r) && cfg_r.irq_gate;
        dma_nxt       = gen_event;
        if (cfg_r.mode != pwmg_pkg::MODE_ONE && cfg_r.mode != pwmg_pkg::MODE_CONT)
        begin
            st_nxt  = pwmg_pkg::ST_IDLE;
            out_nxt = cfg_r.idle_output_level;
            edge_seen_nxt = 1'b0;
        end
        else if (start_pulse && st_r == pwmg_pkg::ST_IDLE)
        begin
            left_nxt = burst_repeat_count_r;
            edge_seen_nxt = 1'b0;
            st_nxt = (cfg_r.trigger_edge_select == pwmg_pkg::TRIG_NONE) ? pwmg_pkg::ST_RUN
                                                                      : pwmg_pkg::ST_ARMED;
            cnt_nxt    = '0;
            sh_per_nxt = period_length_r;
            sh_ph1_nxt = first_phase_length_r;
        end
        else if (!halted)
        begin
            unique case (st_r)
                pwmg_pkg::ST_IDLE: out_nxt = cfg_r.idle_output_level;
                pwmg_pkg::ST_ARMED:
                begin
                    out_nxt = cfg_r.idle_output_level;
                    if (edge_seen_r || edge_now)
                    begin
                        st_nxt = pwmg_pkg::ST_RUN;
                        edge_seen_nxt = 1'b0;
                    end
                end
                pwmg_pkg::ST_RUN:
                begin
                    out_nxt = (cnt_r < sh_ph1_r) ? cfg_r.first_phase_level
                                                 : !cfg_r.first_phase_level;
                    cnt_nxt = cnt_r + 32'h1;
                    if (period_end)
                    begin
                        cnt_nxt = '0;
                        st_nxt = done_event ? pwmg_pkg::ST_IDLE : st_r;
                        left_nxt = done_event ? left_r : left_r - 8'h01;
                        sh_per_nxt = period_length_r;
                        sh_ph1_nxt = first_phase_length_r;
                    end
                end
                default: st_nxt = pwmg_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            aw_addr_r <= '0;
            w_data_r  <= '0;
            w_strb_r  <= '0;
            bvalid_r  <= 1'b0;
            bresp_r   <= pwmg_pkg::RESP_OKAY;
            rvalid_r  <= 1'b0;
            rresp_r   <= pwmg_pkg::RESP_OKAY;
            rdata_r   <= '0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            arready_r <= 1'b1;
            cfg_r     <= '0;
            free_r    <= 1'b0;
            burst_repeat_count_r <= '0;
            period_length_r      <= '0;
            first_phase_length_r <= '0;
            ist_r     <= '0;
            imsk_r    <= '0;
            st_r      <= pwmg_pkg::ST_IDLE;
            cnt_r     <= '0;
            sh_per_r  <= '0;
            sh_ph1_r  <= '0;
            left_r    <= '0;
            out_r     <= 1'b0;
            trig_d_r  <= 1'b0;
            edge_seen_r <= 1'b0;
            irq_r     <= 1'b0;
            dma_r     <= 1'b0;
        end
        else
        begin
            aw_have_r <= aw_have_nxt;
            w_have_r  <= w_have_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_data_r  <= w_data_nxt;
            w_strb_r  <= w_strb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rresp_r   <= rresp_nxt;
            rdata_r   <= rdata_nxt;
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            arready_r <= arready_nxt;
            cfg_r     <= cfg_nxt;
            free_r    <= free_nxt;
            burst_repeat_count_r <= burst_repeat_count_nxt;
            period_length_r      <= period_length_nxt;
            first_phase_length_r <= first_phase_length_nxt;
            ist_r     <= ist_nxt;
            imsk_r    <= imsk_nxt;
            st_r      <= st_nxt;
            cnt_r     <= cnt_nxt;
            sh_per_r  <= sh_per_nxt;
            sh_ph1_r  <= sh_ph1_nxt;
            left_r    <= left_nxt;
            out_r     <= out_nxt;
            trig_d_r  <= trig_in;
            edge_seen_r <= edge_seen_nxt;
            irq_r     <= irq_nxt;
            dma_r     <= dma_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;
    assign pwm_out       = out_r;
    assign irq           = irq_r;
    assign dma_req       = dma_r;

    run_flag_a: assert property (@(posedge clock) disable iff (!rst_b)
        s_axi_rvalid && $past(s_axi_arvalid && s_axi_arready && s_axi_araddr == pwmg_pkg::ADDR_CFG)
        |-> s_axi_rdata[pwmg_pkg::RUN_BIT] == $past(st_r != pwmg_pkg::ST_IDLE))
        else $error("run flag wrong");
    live_level_a: assert property (@(posedge clock) disable iff (!rst_b)
        s_axi_rvalid && $past(s_axi_arvalid && s_axi_arready && s_axi_araddr == pwmg_pkg::ADDR_CFG)
        |-> s_axi_rdata[pwmg_pkg::LEVEL_BIT] == $past(pwm_out))
        else $error("level flag wrong");
    start_run_a: assert property (@(posedge clock) disable iff (!rst_b)
        start_pulse && st_r == pwmg_pkg::ST_IDLE && cfg_r.mode == pwmg_pkg::MODE_CONT
        && cfg_r.trigger_edge_select == pwmg_pkg::TRIG_NONE |=> st_r == pwmg_pkg::ST_RUN)
        else $error("start ignored");
    zero_start_a: assert property (@(posedge clock) disable iff (!rst_b)
        st_r == pwmg_pkg::ST_IDLE && !start_pulse && cfg_nxt.mode == cfg_r.mode |=> st_r == pwmg_pkg::ST_IDLE)
        else $error("started without start bit");
    period_len_a: assert property (@(posedge clock) disable iff (!rst_b)
        period_end |-> cnt_r == sh_per_r ##1 cnt_r == 32'h0)
        else $error("period length wrong");
    phase_level_a: assert property (@(posedge clock) disable iff (!rst_b)
        st_r == pwmg_pkg::ST_RUN && !halted && $stable(cfg_r)
        |=> pwm_out == ($past(cnt_r < sh_ph1_r) ? $past(cfg_r.first_phase_level)
                                                : !$past(cfg_r.first_phase_level)))
        else $error("phase level wrong");
    idle_level_a: assert property (@(posedge clock) disable iff (!rst_b)
        st_r == pwmg_pkg::ST_IDLE && !halted && $stable(cfg_r) ##1 st_r == pwmg_pkg::ST_IDLE
        |-> pwm_out == $past(cfg_r.idle_output_level))
        else $error("idle level wrong");
    oneshot_end_a: assert property (@(posedge clock) disable iff (!rst_b)
        done_event |=> st_r == pwmg_pkg::ST_IDLE && ist_r[0])
        else $error("one-shot end missed");
    dma_pair_a: assert property (@(posedge clock) disable iff (!rst_b)
        gen_event |=> dma_req ##1 !dma_req || $past(gen_event))
        else $error("dma request wrong");
    halt_freeze_a: assert property (@(posedge clock) disable iff (!rst_b)
        halted && st_r == pwmg_pkg::ST_RUN && !start_pulse |=> $stable(cnt_r) && $stable(pwm_out))
        else $error("halt did not freeze");
    armed_wait_a: assert property (@(posedge clock) disable iff (!rst_b)
        st_r == pwmg_pkg::ST_ARMED && !edge_seen_r && !edge_now && cfg_r.mode != pwmg_pkg::MODE_OFF
        |=> st_r != pwmg_pkg::ST_RUN)
        else $error("ran without trigger");
endmodule // pwmg_top

// file: hw/pwmg_pkg.sv
// shared constants and types for the waveform generator
package pwmg_pkg;
    localparam logic [4:0] ADDR_CTRL  = 5'h04;
    localparam logic [4:0] ADDR_CFG   = 5'h08;
    localparam logic [4:0] ADDR_RUN   = 5'h0C;
    localparam logic [4:0] ADDR_REPEAT = 5'h10;
    localparam logic [4:0] ADDR_PER   = 5'h14;
    localparam logic [4:0] ADDR_PH1   = 5'h18;
    localparam logic [4:0] ADDR_IST   = 5'h1C;
    localparam logic [4:0] ADDR_IMSK  = 5'h00;
    localparam int         MODE_LO    = 0;
    localparam int         TRIG_LO    = 2;
    localparam int         P1_BIT     = 4;
    localparam int         IDLE_BIT   = 5;
    localparam int         IRQ_BIT    = 6;
    localparam int         LEVEL_BIT  = 16;
    localparam int         RUN_BIT    = 17;
    localparam logic [1:0] MODE_OFF   = 2'h0;
    localparam logic [1:0] MODE_ONE   = 2'h1;
    localparam logic [1:0] MODE_CONT  = 2'h2;
    localparam logic [1:0] TRIG_NONE  = 2'h0;
    localparam logic [1:0] TRIG_RISE  = 2'h1;
    localparam logic [1:0] TRIG_FALL  = 2'h2;
    localparam logic [6:0] CFG_WMASK  = 7'h7F;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       irq_gate;
        logic       idle_output_level;
        logic       first_phase_level;
        logic [1:0] trigger_edge_select;
        logic [1:0] mode;
    } pwmg_cfg_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ARMED = 3'b010,
        ST_RUN   = 3'b100
    } pwmg_state_t;
endpackage

// file: tb/pwmg_far_model.sv
// far side: trigger source and output pin monitor
module pwmg_far_model (
    input  wire logic clock,
    input  wire logic pwm_out,
    output logic      trig_in
);
    timeunit 1ns;
    timeprecision 100ps;
    int   cyc    = 0;
    int   n_rise = 0;
    int   n_high = 0;
    int   t_rise = 0;
    int   t_fall = 0;
    int   p_last = 0;
    logic last   = 1'b0;
    initial trig_in = 1'b0;
    always @(posedge clock)
    begin
        cyc  <= cyc + 1;
        last <= pwm_out;
        if (pwm_out === 1'b1)
            n_high <= n_high + 1;
        if (pwm_out === 1'b1 && last === 1'b0)
        begin
            n_rise <= n_rise + 1;
            p_last <= cyc - t_rise;
            t_rise <= cyc;
        end
        if (pwm_out === 1'b0 && last === 1'b1)
            t_fall <= cyc;
    end
    // one edge of the chosen sense, then back low
    task pulse_trig(input logic rising);
        trig_in <= ~rising;
        repeat (3) @(posedge clock);
        trig_in <= rising;
        repeat (3) @(posedge clock);
        trig_in <= 1'b0;
    endtask
endmodule // pwmg_far_model

// file: tb/tb_pwmg_top.sv
// register-level testbench for the waveform generator
module tb_pwmg_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock         = 1'b0;
    logic        rst_b         = 1'b0;
    logic [4:0]  s_axi_awaddr  = 5'h00;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata   = 32'h0;
    logic [3:0]  s_axi_wstrb   = 4'hF;
    logic        s_axi_wvalid  = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready  = 1'b0;
    logic [4:0]  s_axi_araddr  = 5'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready  = 1'b0;
    logic        trig_in;
    logic        debug_halt    = 1'b0;
    logic        pwm_out;
    logic        irq;
    logic        dma_req;
    int          n_errors      = 0;
    int          comparisons   = 0;
    int          n_dma         = 0;
    pwmg_top uut (.clock(clock), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .trig_in(trig_in), .debug_halt(debug_halt),
        .pwm_out(pwm_out), .irq(irq), .dma_req(dma_req));
    pwmg_far_model far (.clock(clock), .pwm_out(pwm_out), .trig_in(trig_in));
    always #4 clock = ~clock;
    always @(posedge clock)
        if (dma_req === 1'b1)
            n_dma <= n_dma + 1;
    task close_out;
        $display("mismatches %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task stall;
        n_errors++;
        $display("BAD %0t wait ran out", $time);
        close_out;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
            begin
                n_errors++;
                $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
            end
    endtask
    task wr(input logic [4:0] a, input logic [31:0] d);
        int i;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (i = 0; i < 100; i++)
        begin
            @(posedge clock);
            if (s_axi_bvalid === 1'b1)
                break;
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end
        if (i == 100)
            stall();
        chk(32'(s_axi_bresp), 32'(pwmg_pkg::RESP_OKAY), "write response");
        s_axi_bready <= 1'b0;
        @(posedge clock);
    endtask
    task rd(input logic [4:0] a, output logic [31:0] d);
        int i;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (i = 0; i < 100; i++)
        begin
            @(posedge clock);
            if (s_axi_rvalid === 1'b1)
                break;
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end
        if (i == 100)
            stall();
        chk(32'(s_axi_rresp), 32'(pwmg_pkg::RESP_OKAY), "read response");
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        @(posedge clock);
    endtask
    task wait_dma(input int target);
        int i;
        for (i = 0; i < 400 && n_dma < target; i++)
            @(posedge clock);
        if (i == 400)
            stall();
    endtask
    logic [4:0]  regs [4] = '{pwmg_pkg::ADDR_CFG, pwmg_pkg::ADDR_REPEAT, pwmg_pkg::ADDR_PER, pwmg_pkg::ADDR_PH1};
    logic [31:0] v;
    logic        lv;
    int          r0;
    int          h0;
    int          d0;
    initial
    begin
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        for (int k = 0; k < 4; k++)
        begin
            rd(regs[k], v);
            chk(v, 32'h0, "reset value");
        end
        chk(32'({pwm_out, irq, dma_req}), 32'h0, "outputs after reset");
        rd(pwmg_pkg::ADDR_RUN, v);
        chk(v, 32'h0, "start reads zero");
        wr(pwmg_pkg::ADDR_CFG, 32'h0000_0060);
        rd(pwmg_pkg::ADDR_CFG, v);
        chk(v, 32'h0001_0060, "idle level readback");
        chk(32'(pwm_out), 32'h1, "idle level on pin");
        $display("test reset and idle done");
        wr(pwmg_pkg::ADDR_PER, 32'h5);
        wr(pwmg_pkg::ADDR_PH1, 32'h2);
        wr(pwmg_pkg::ADDR_REPEAT, 32'h2);
        wr(pwmg_pkg::ADDR_IMSK, 32'h1);
        wr(pwmg_pkg::ADDR_CFG, 32'h51);
        wr(pwmg_pkg::ADDR_RUN, 32'h0);
        rd(pwmg_pkg::ADDR_CFG, v);
        chk(v, 32'h51, "zero start does not run");
        r0 = far.n_rise;
        h0 = far.n_high;
        d0 = n_dma;
        wr(pwmg_pkg::ADDR_RUN, 32'h1);
        rd(pwmg_pkg::ADDR_CFG, v);
        chk(32'(v[17]), 32'h1, "running flag");
        wait_dma(d0 + 1);
        repeat (3) @(posedge clock);
        chk(far.n_rise - r0, 32'h3, "burst periods");
        chk(far.n_high - h0, 32'h6, "first-phase cycles");
        chk(far.t_fall - far.t_rise, 32'h2, "first-phase width");
        chk(far.p_last, 32'h6, "period length");
        chk(32'(irq), 32'h1, "burst interrupt");
        chk(n_dma - d0, 32'h1, "one dma request");
        rd(pwmg_pkg::ADDR_IST, v);
        chk(v, 32'h1, "done status");
        rd(pwmg_pkg::ADDR_CFG, v);
        chk(v, 32'h51, "idle after burst");
        wr(pwmg_pkg::ADDR_IST, 32'h1);
        chk(32'(irq), 32'h0, "interrupt cleared");
        $display("test one-shot done");
        wr(pwmg_pkg::ADDR_IMSK, 32'h0);
        wr(pwmg_pkg::ADDR_REPEAT, 32'h0);
        wr(pwmg_pkg::ADDR_CFG, 32'h59);
        r0 = far.n_rise;
        d0 = n_dma;
        wr(pwmg_pkg::ADDR_RUN, 32'h1);
        repeat (20) @(posedge clock);
        chk(far.n_rise - r0, 32'h0, "armed waits for edge");
        far.pulse_trig(1'b0);
        wait_dma(d0 + 1);
        repeat (3) @(posedge clock);
        chk(far.n_rise - r0, 32'h1, "single triggered period");
        chk(32'(irq), 32'h0, "masked interrupt");
        rd(pwmg_pkg::ADDR_IST, v);
        chk(v, 32'h1, "masked status set");
        wr(pwmg_pkg::ADDR_IST, 32'h1);
        $display("test falling trigger done");
        wr(pwmg_pkg::ADDR_IMSK, 32'h2);
        wr(pwmg_pkg::ADDR_CFG, 32'h56);
        wr(pwmg_pkg::ADDR_RUN, 32'h1);
        far.pulse_trig(1'b1);
        d0 = n_dma;
        wait_dma(d0 + 3);
        chk(32'(irq), 32'h1, "reload interrupt");
        chk(far.p_last, 32'h6, "continuous period");
        debug_halt <= 1'b1;
        repeat (2) @(posedge clock);
        d0 = n_dma;
        lv = pwm_out;
        repeat (20) @(posedge clock);
        chk(n_dma - d0, 32'h0, "halt freezes events");
        chk(32'(pwm_out), 32'(lv), "halt freezes pin");
        wr(pwmg_pkg::ADDR_CTRL, 32'h1);
        d0 = n_dma;
        repeat (20) @(posedge clock);
        chk(32'(n_dma > d0), 32'h1, "free-run continues");
        debug_halt <= 1'b0;
        wr(pwmg_pkg::ADDR_CTRL, 32'h0);
        wr(pwmg_pkg::ADDR_CFG, 32'h0);
        rd(pwmg_pkg::ADDR_CFG, v);
        chk(v, 32'h0, "disable stops");
        wr(pwmg_pkg::ADDR_CFG, 32'h43);
        wr(pwmg_pkg::ADDR_RUN, 32'h1);
        rd(pwmg_pkg::ADDR_CFG, v);
        chk(v, 32'h43, "reserved mode idle");
        $display("test continuous and halt done");
        close_out;
    end
endmodule // tb_pwmg_top
